// File: src/tap_pkg.sv
// Register map, field layout, reset values and codes of the sequencer
package tap_pkg;
   // ****************************************
   // Register offsets (byte addresses)
   // ****************************************
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_CMD1 = 8'h04;
   localparam logic [7:0] OFF_CMD2 = 8'h08;
   localparam logic [7:0] OFF_VEL  = 8'h0c;
   localparam logic [7:0] OFF_CFG  = 8'h10;
   localparam logic [7:0] OFF_JOG  = 8'h14;
   localparam logic [7:0] OFF_WIN  = 8'h18;
   localparam logic [7:0] OFF_FSV  = 8'h1c;
   localparam logic [7:0] OFF_DBND = 8'h20;
   localparam logic [7:0] OFF_STAT = 8'h24;
   localparam logic [7:0] OFF_TGT1 = 8'h28;
   localparam logic [7:0] OFF_TGT2 = 8'h2c;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int C_EN   = 0;
   localparam int C_JA1  = 1;
   localparam int C_JB1  = 2;
   localparam int C_ST1  = 3;
   localparam int C_JA2  = 4;
   localparam int C_JB2  = 5;
   localparam int C_ST2  = 6;
   localparam int C_SYNC = 7;
   localparam int C_AVG  = 8;
   localparam int F_CRV1 = 0;
   localparam int F_CRV2 = 2;
   localparam int F_FE1  = 4;
   localparam int F_FS1  = 6;
   localparam int F_SH1  = 8;
   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [8:0]  CTRL_RST = 9'h000;
   localparam logic [9:0]  CFG_RST  = 10'h005;
   localparam logic [15:0] VEL_RST  = 16'h7fff;
   localparam logic [15:0] JOG_RST  = 16'h0400;
   localparam logic [15:0] WIN_RST  = 16'h0010;
   localparam logic [15:0] FSV_RST  = 16'h0000;
   localparam logic [15:0] DBND_RST = 16'h0000;
   // ****************************************
   // Braking curves and their gains
   // ****************************************
   typedef enum logic [1:0] {
      TAP_LIN   = 2'h0,
      TAP_MILD  = 2'h1,
      TAP_STEEP = 2'h2
   } tap_curve_t;
   localparam logic [2:0] GAIN_LIN   = 3'h1;
   localparam logic [2:0] GAIN_MILD  = 3'h3;
   localparam logic [2:0] GAIN_STEEP = 3'h5;
endpackage : tap_pkg

// File: src/tap_sync2.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module tap_sync2 #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Asynchronous in, synchronous out
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   // ****************************************
   // Two stages, first one read only here
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule : tap_sync2

// File: src/tap_axis.sv
// Per-axis valve drive: jog, closed loop, failsafe, in-window flag
`timescale 1ns/1ns
module tap_axis (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               rst_n,
   // Axis control
   input  wire logic               active,
   input  wire logic               jog_dir_a_bit,
   input  wire logic               jog_dir_b_bit,
   input  wire logic               start,
   input  wire logic [15:0]        pos,
   input  wire logic [15:0]        target,
   // Settings
   input  wire logic [15:0]        vel,
   input  wire logic [15:0]        manual_jog_speed,
   input  wire logic [15:0]        arrival_window,
   input  wire logic [15:0]        dband,
   input  wire logic [15:0]        failsafe_output,
   input  wire logic               failsafe_en,
   input  wire logic [1:0]         curve,
   input  wire logic               follow_err,
   input  wire logic               shaping_en,
   // Results
   output logic signed [15:0]      drive,
   output logic                    target_reached_flag
);
   logic signed [16:0] err;
   logic        [16:0] mag;
   logic        [2:0]  gain;
   logic        [19:0] scaled;
   logic        [20:0] shaped;
   logic        [21:0] comp;
   logic        [14:0] lim;
   logic signed [15:0] closed;
   logic signed [15:0] jog_drv;
   logic               in_win;
   logic               jog;
   logic signed [15:0] next_drive;

   // ****************************************
   // Closed-loop output shaping
   // ****************************************
   assign err = $signed({1'b0, target}) - $signed({1'b0, pos});
   assign mag = err[16] ? 17'(-err) : 17'(err);
   assign in_win = mag <= {1'b0, arrival_window};
   // Curve gain at the target
   assign gain = (curve == tap_pkg::TAP_MILD)  ? tap_pkg::GAIN_MILD :  // see RULE10
                 (curve == tap_pkg::TAP_STEEP) ? tap_pkg::GAIN_STEEP : // see RULE11
                 tap_pkg::GAIN_LIN;                                    // see RULE9
   // Scaled braking or following-error method
   assign scaled = follow_err ? {3'h0, mag}
                              : {3'h0, mag} * {17'h0, gain};           // see RULE7
   // Two-slope characteristic instead of an overlap step
   assign shaped = !shaping_en ? {1'b0, scaled} :
                   in_win ? {scaled, 1'b0} :
                   {1'b0, scaled} + {5'h0, arrival_window};           // see RULE12
   // Deadband offset; too large a value sets a least speed
   assign comp = {1'b0, shaped} + ((mag != 17'h0) ? {6'h0, dband} : 22'h0); // see RULE13
   assign lim = (comp > {7'h0, vel[14:0]}) ? vel[14:0] : comp[14:0];
   assign closed = err[16] ? 16'(-$signed({1'b0, lim})) : $signed({1'b0, lim});
   // Open-loop jog speed, no position control
   assign jog = jog_dir_a_bit | jog_dir_b_bit;
   assign jog_drv = jog_dir_a_bit ? $signed({1'b0, manual_jog_speed[14:0]})
                  : 16'(-$signed({1'b0, manual_jog_speed[14:0]}));   // see RULE1
   // Output selection by priority
   assign next_drive = !active ? (failsafe_en ? $signed(failsafe_output)
                                              : 16'sh0000) :          // see RULE8
                       (jog_dir_a_bit & jog_dir_b_bit) ? 16'sh0000 :
                       jog ? jog_drv : closed;

   // ****************************************
   // Registered drive and arrival flag
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         drive               <= 16'sh0000;
         target_reached_flag <= 1'b0;
      end else begin
         drive               <= next_drive;
         target_reached_flag <= active & start & !jog & in_win; // see RULE4
      end
   end
endmodule : tap_axis

// File: src/tap_sequencer.sv
// Two-axis position sequencer: registers, targets, sync and status
`timescale 1ns/1ns

// Behaviour
// RULE1: A set jog bit drives the axis open loop at the jog speed in its direction. The code drives zero when both jog bits of an axis are set.
// RULE2: When jogging stops the measured position becomes the target again.
// RULE3: While start is set the command position is taken as target at once.
// RULE4: The reached flag is set inside the window while start stays set.
// RULE5: The sync bit couples both axes by master-slave or averaging.
// RULE6: In master-slave sync the second axis follows the first axis.
// RULE7: Two methods exist, scaled braking gain or following-error output.
// RULE8: On failure the output is forced to the failsafe value if enabled per axis.
// RULE9: The linear curve multiplies the gain by one, per axis.
// RULE10: The mild root curve raises gain by three and is the reset choice.
// RULE11: The steep root curve raises gain by five.
// RULE12: Gain shaping applies a two-slope characteristic per axis.
// RULE13: The deadband offset adds compensation to the output.
// RULE14: Ready is high only with pin enable, bus enable and no sensor error.
// RULE15: On enable the target equals the actual position and the axis holds.
// RULE16: While jogging, start-triggered target updates are ignored.
module tap_sequencer (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               rst_n,
   // Wishbone slave
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   input  wire logic               wb_we_i,
   input  wire logic [7:0]         wb_adr_i,
   input  wire logic [3:0]         wb_sel_i,
   input  wire logic [31:0]        wb_dat_i,
   output logic      [31:0]        wb_dat_o,
   output logic                    wb_ack_o,
   // Card pins
   input  wire logic               enable_pin,
   input  wire logic               sensor_err1,
   input  wire logic               sensor_err2,
   // Measured positions
   input  wire logic [15:0]        meas_pos1,
   input  wire logic [15:0]        meas_pos2,
   // Status and valve drive
   output logic                    ready,
   output logic                    target_reached1,
   output logic                    target_reached2,
   output logic signed [15:0]      drive1,
   output logic signed [15:0]      drive2
);
   // ****************************************
   // Declarations
   // ****************************************
   logic [8:0]  ctrl;
   logic [9:0]  cfg;
   logic [15:0] cmd1;
   logic [15:0] cmd2;
   logic [15:0] vel;
   logic [15:0] jog_spd;
   logic [15:0] win;
   logic [15:0] fsv;
   logic [15:0] dbnd;
   logic [2:0]  pin_s;
   logic        ok;
   logic        req;
   logic        wr;
   logic [31:0] rd_data;
   logic [31:0] stat;
   logic [15:0] tgt      [2];
   logic [15:0] pos      [2];
   logic [15:0] cmd      [2];
   logic [15:0] eff_t    [2];
   logic [15:0] avg_t;
   logic [16:0] sum_t;
   logic [1:0]  ja;
   logic [1:0]  jb;
   logic [1:0]  st;
   logic [1:0]  jog;
   logic [1:0]  jog_prev;
   logic [1:0]  reached;
   logic signed [15:0] drv [2];
   logic        sync;
   logic        avg;
   logic        hit_ctrl;
   logic        hit_cmd1;
   logic        hit_cmd2;
   logic        hit_vel;
   logic        hit_cfg;
   logic        hit_jog;
   logic        hit_win;
   logic        hit_fsv;
   logic        hit_dbnd;
   logic        hit_stat;
   logic        hit_tgt1;
   logic        hit_tgt2;

   // ****************************************
   // Byte-lane merge of a write
   // ****************************************
   function automatic logic [31:0] tap_merge(input logic [31:0] old,
                                             input logic [31:0] din,
                                             input logic [3:0]  sel);
      logic [31:0] m;
      m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      return (old & ~m) | (din & m);
   endfunction : tap_merge

   // ****************************************
   // Pin synchronisers
   // ****************************************
   tap_sync2 #(
      .W (3)
   ) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({sensor_err2, sensor_err1, enable_pin}),
      .q     (pin_s)
   );

   // ****************************************
   // Bus decode
   // ****************************************
   assign req      = wb_cyc_i & wb_stb_i & !wb_ack_o;
   assign wr       = req & wb_we_i;
   assign hit_ctrl = wb_adr_i == tap_pkg::OFF_CTRL;
   assign hit_cmd1 = wb_adr_i == tap_pkg::OFF_CMD1;
   assign hit_cmd2 = wb_adr_i == tap_pkg::OFF_CMD2;
   assign hit_vel  = wb_adr_i == tap_pkg::OFF_VEL;
   assign hit_cfg  = wb_adr_i == tap_pkg::OFF_CFG;
   assign hit_jog  = wb_adr_i == tap_pkg::OFF_JOG;
   assign hit_win  = wb_adr_i == tap_pkg::OFF_WIN;
   assign hit_fsv  = wb_adr_i == tap_pkg::OFF_FSV;
   assign hit_dbnd = wb_adr_i == tap_pkg::OFF_DBND;
   assign hit_stat = wb_adr_i == tap_pkg::OFF_STAT;
   assign hit_tgt1 = wb_adr_i == tap_pkg::OFF_TGT1;
   assign hit_tgt2 = wb_adr_i == tap_pkg::OFF_TGT2;

   // Status word: live state of the sequencer
   assign stat = {25'h0, jog, pin_s[2], pin_s[1], reached, ready};

   // Read selection, unmapped reads as zero
   assign rd_data = hit_ctrl ? {23'h0, ctrl} :
                    hit_cmd1 ? {16'h0, cmd1} :
                    hit_cmd2 ? {16'h0, cmd2} :
                    hit_vel  ? {16'h0, vel} :
                    hit_cfg  ? {22'h0, cfg} :
                    hit_jog  ? {16'h0, jog_spd} :
                    hit_win  ? {16'h0, win} :
                    hit_fsv  ? {16'h0, fsv} :
                    hit_dbnd ? {16'h0, dbnd} :
                    hit_stat ? stat :
                    hit_tgt1 ? {16'h0, tgt[0]} :
                    hit_tgt2 ? {16'h0, tgt[1]} :
                    32'h0000_0000;

   // ****************************************
   // Bus answer: one ack per request
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= req ? rd_data : 32'h0000_0000;
      end
   end

   // ****************************************
   // Software registers
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl    <= tap_pkg::CTRL_RST;
         cfg     <= tap_pkg::CFG_RST;   // see RULE10
         cmd1    <= 16'h0000;
         cmd2    <= 16'h0000;
         vel     <= tap_pkg::VEL_RST;
         jog_spd <= tap_pkg::JOG_RST;
         win     <= tap_pkg::WIN_RST;
         fsv     <= tap_pkg::FSV_RST;
         dbnd    <= tap_pkg::DBND_RST;
      end else if (wr) begin
         if (hit_ctrl) ctrl <= 9'(tap_merge({23'h0, ctrl}, wb_dat_i, wb_sel_i));
         if (hit_cfg)  cfg  <= 10'(tap_merge({22'h0, cfg}, wb_dat_i, wb_sel_i));
         if (hit_cmd1) cmd1 <= 16'(tap_merge({16'h0, cmd1}, wb_dat_i, wb_sel_i));
         if (hit_cmd2) cmd2 <= 16'(tap_merge({16'h0, cmd2}, wb_dat_i, wb_sel_i));
         if (hit_vel)  vel  <= 16'(tap_merge({16'h0, vel}, wb_dat_i, wb_sel_i));
         if (hit_jog)  jog_spd <= 16'(tap_merge({16'h0, jog_spd}, wb_dat_i, wb_sel_i));
         if (hit_win)  win  <= 16'(tap_merge({16'h0, win}, wb_dat_i, wb_sel_i));
         if (hit_fsv)  fsv  <= 16'(tap_merge({16'h0, fsv}, wb_dat_i, wb_sel_i));
         if (hit_dbnd) dbnd <= 16'(tap_merge({16'h0, dbnd}, wb_dat_i, wb_sel_i));
      end
   end

   // ****************************************
   // Ready from pin, bus enable and sensors
   // ****************************************
   assign ok = pin_s[0] & ctrl[tap_pkg::C_EN] & !pin_s[1] & !pin_s[2]; // see RULE14

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ready <= 1'b0;
      end else begin
         ready <= ok;
      end
   end

   // ****************************************
   // Per-axis control bits
   // ****************************************
   assign ja     = {ctrl[tap_pkg::C_JA2], ctrl[tap_pkg::C_JA1]};
   assign jb     = {ctrl[tap_pkg::C_JB2], ctrl[tap_pkg::C_JB1]};
   assign st     = {ctrl[tap_pkg::C_ST2], ctrl[tap_pkg::C_ST1]};
   assign jog    = ja | jb;
   assign sync   = ctrl[tap_pkg::C_SYNC];
   assign avg    = ctrl[tap_pkg::C_AVG];
   assign pos[0] = meas_pos1;
   assign pos[1] = meas_pos2;
   assign cmd[0] = cmd1;
   assign cmd[1] = cmd2;

   // ****************************************
   // Axis coupling
   // ****************************************
   assign sum_t    = {1'b0, tgt[0]} + {1'b0, tgt[1]};
   assign avg_t    = sum_t[16:1];
   // Averaging: both axes chase the mean target
   assign eff_t[0] = (sync & avg) ? avg_t : tgt[0];           // see RULE5
   // Master-slave: second axis follows the first one
   assign eff_t[1] = !sync ? tgt[1] : avg ? avg_t : meas_pos1; // see RULE6

   // ****************************************
   // Targets and axis drives
   // ****************************************
   for (genvar g = 0; g < 2; g++) begin : g_axis
      // Target: hold actual when idle or jogging, else take command on start
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            tgt[g]      <= 16'h0000;
            jog_prev[g] <= 1'b0;
         end else begin
            jog_prev[g] <= jog[g];
            if (!ready) begin
               tgt[g] <= pos[g];                 // see RULE15
            end else if (jog[g] | jog_prev[g]) begin
               tgt[g] <= pos[g];                 // see RULE2 RULE16
            end else if (st[g]) begin
               tgt[g] <= cmd[g];                 // see RULE3
            end
         end
      end

      tap_axis u_axis (
         .clk                 (clk),
         .rst_n               (rst_n),
         .active              (ready),
         .jog_dir_a_bit       (ja[g]),
         .jog_dir_b_bit       (jb[g]),
         .start               (st[g]),
         .pos                 (pos[g]),
         .target              (eff_t[g]),
         .vel                 (vel),
         .manual_jog_speed    (jog_spd),
         .arrival_window      (win),
         .dband               (dbnd),
         .failsafe_output     (fsv),
         .failsafe_en         (cfg[tap_pkg::F_FS1 + g]),
         .curve               (cfg[tap_pkg::F_CRV1 + 2*g +: 2]),
         .follow_err          (cfg[tap_pkg::F_FE1 + g]),
         .shaping_en          (cfg[tap_pkg::F_SH1 + g]),
         .drive               (drv[g]),
         .target_reached_flag (reached[g])
      );
   end

   // Outputs taken from the axis flip-flops
   assign drive1          = drv[0];
   assign drive2          = drv[1];
   assign target_reached1 = reached[0];
   assign target_reached2 = reached[1];

   // ****************************************
   // Assertions
   // ****************************************
   property p_ready_pin;
      @(posedge clk) disable iff (!rst_n)
      !enable_pin ##1 !enable_pin ##1 !enable_pin |=> !ready;
   endproperty
   a_ready_pin: assert property (p_ready_pin) // see RULE14
      else $error("ready high without enable pin");

   property p_ready_bus;
      @(posedge clk) disable iff (!rst_n)
      !ctrl[tap_pkg::C_EN] |=> !ready;
   endproperty
   a_ready_bus: assert property (p_ready_bus) // see RULE14
      else $error("ready high without bus enable");

   property p_hold_actual;
      @(posedge clk) disable iff (!rst_n)
      !ready |=> tgt[0] == $past(meas_pos1);
   endproperty
   a_hold_actual: assert property (p_hold_actual) // see RULE15
      else $error("target not tracking actual while disabled");

   property p_jog_release;
      @(posedge clk) disable iff (!rst_n)
      ready && jog_prev[0] && !jog[0] |=> tgt[0] == $past(meas_pos1);
   endproperty
   a_jog_release: assert property (p_jog_release) // see RULE2
      else $error("position not latched at jog release");

   property p_start_take;
      @(posedge clk) disable iff (!rst_n)
      ready && st[0] && !jog[0] && !jog_prev[0] |=> tgt[0] == $past(cmd1);
   endproperty
   a_start_take: assert property (p_start_take) // see RULE3
      else $error("command position not taken on start");

   property p_jog_blocks;
      @(posedge clk) disable iff (!rst_n)
      ready && jog[0] && st[0] |=> tgt[0] != $past(cmd1) || $past(cmd1 == meas_pos1);
   endproperty
   a_jog_blocks: assert property (p_jog_blocks) // see RULE16
      else $error("start updated target during jog");

   property p_jog_drive;
      @(posedge clk) disable iff (!rst_n)
      ready && ja[0] && !jb[0] |=> drive1 == $signed({1'b0, $past(jog_spd[14:0])});
   endproperty
   a_jog_drive: assert property (p_jog_drive) // see RULE1
      else $error("jog drive not at jog speed");

   property p_failsafe;
      @(posedge clk) disable iff (!rst_n)
      !ready && cfg[tap_pkg::F_FS1] |=> drive1 == $signed($past(fsv));
   endproperty
   a_failsafe: assert property (p_failsafe) // see RULE8
      else $error("failsafe value not driven");

   property p_reached_start;
      @(posedge clk) disable iff (!rst_n)
      !st[0] |=> !target_reached1;
   endproperty
   a_reached_start: assert property (p_reached_start) // see RULE4
      else $error("reached flag without start");

   property p_average;
      @(posedge clk) disable iff (!rst_n)
      ready && sync && avg |-> eff_t[0] == eff_t[1] &&
         (17'(tgt[0]) + 17'(tgt[1]) - {eff_t[1], 1'b0}) <= 17'h1;
   endproperty
   a_average: assert property (p_average) // see RULE5
      else $error("averaging targets differ");

   property p_slave;
      @(posedge clk) disable iff (!rst_n)
      ready && sync && !avg && !jog[1] && vel[14:0] != 15'h0
      |=> (drive2 == 16'sh0000) == ($past(meas_pos1) == $past(meas_pos2));
   endproperty
   a_slave: assert property (p_slave) // see RULE6
      else $error("slave axis not following first axis");

   // Main scenarios
   c_jog_release: cover property (@(posedge clk) disable iff (!rst_n)
      ready && jog_prev[0] && !jog[0]);
   c_reached: cover property (@(posedge clk) disable iff (!rst_n)
      $rose(target_reached1));
   c_sync: cover property (@(posedge clk) disable iff (!rst_n)
      ready && sync && st[1]);
endmodule : tap_sequencer

// File: test/tap_bus_master.sv
// Wishbone master standing in for the fieldbus controller
`timescale 1ns/1ns
module tap_bus_master (
   // Clock
   input  wire logic        clk,
   // Wishbone master side
   output logic             cyc,
   output logic             stb,
   output logic             we,
   output logic [7:0]       adr,
   output logic [31:0]      dat,
   input  wire logic        ack,
   input  wire logic [31:0] dat_in
);
   int timeouts = 0;
   // Idle bus at time zero
   initial begin
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      dat = 32'h0;
   end
   // One classic cycle held until ack is seen or 50 clocks pass
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (ack !== 1'b1) timeouts++;
      q = dat_in;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : xfer
endmodule : tap_bus_master

// File: test/tb_top.sv
// Self-checking bench of the two-axis sequencer
`timescale 1ns/1ns
module tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic enable_pin = 1'b0;
   logic err1 = 1'b0;
   logic [15:0] pos1 = 16'h0;
   logic [15:0] pos2 = 16'h0;
   logic cyc, stb, we, ack, rdy, rch1, rch2;
   logic [7:0] adr;
   logic [31:0] wdat, rdat;
   logic signed [15:0] drv1, drv2;
   int miscompares = 0;
   int n_checks = 0;
   tap_bus_master bm (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .dat(wdat),
                      .ack(ack), .dat_in(rdat));
   tap_sequencer dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .enable_pin(enable_pin), .sensor_err1(err1), .sensor_err2(1'b0),
      .meas_pos1(pos1), .meas_pos2(pos2), .ready(rdy), .target_reached1(rch1),
      .target_reached2(rch2), .drive1(drv1), .drive2(drv2));
   // Clock of 40 ns
   initial begin
      forever #20 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bm.xfer(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bm.xfer(1'b0, a, 32'h0, q);
      chk(nm, e, q);
   endtask : rd
   task automatic pins(input logic en, input logic [15:0] p1, input logic [15:0] p2);
      @(posedge clk);
      enable_pin <= en;
      pos1 <= p1;
      pos2 <= p2;
   endtask : pins
   task automatic wait_ready();
      int n;
      n = 0;
      while (rdy !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      chk("ready", 32'h1, {31'h0, rdy});
   endtask : wait_ready
   task automatic t_reset();
      rd("cfg", tap_pkg::OFF_CFG, 32'h005);
      rd("vel", tap_pkg::OFF_VEL, 32'h7fff);
      rd("unmapped", 8'h3c, 32'h0);
   endtask : t_reset
   task automatic t_enable();
      pins(1'b1, 16'h0100, 16'h0080);
      wr(tap_pkg::OFF_CTRL, 32'h1);
      wait_ready();
      rd("tgt1", tap_pkg::OFF_TGT1, 32'h0100);
      @(posedge clk);
      err1 <= 1'b1;
      repeat (5) @(posedge clk);
      chk("ready err", 32'h0, {31'h0, rdy});
      err1 <= 1'b0;
      wait_ready();
   endtask : t_enable
   task automatic t_start();
      logic [31:0] cfgs [5] = '{32'h000, 32'h001, 32'h002, 32'h015, 32'h105};
      logic [31:0] exp_drv [5] = '{32'hfffb, 32'hfff1, 32'hffe7, 32'hfffb, 32'hffe2};
      wr(tap_pkg::OFF_CMD1, 32'h0200);
      pins(1'b1, 16'h0205, 16'h0080);
      wr(tap_pkg::OFF_CTRL, 32'h9);
      repeat (4) @(posedge clk);
      rd("tgt1", tap_pkg::OFF_TGT1, 32'h0200);
      chk("reached1", 32'h1, {31'h0, rch1});
      for (int i = 0; i < 5; i++) begin
         wr(tap_pkg::OFF_CFG, cfgs[i]);
         repeat (4) @(posedge clk);
         chk("drive1 curve", exp_drv[i], {16'h0, drv1});
      end
      wr(tap_pkg::OFF_DBND, 32'h4);
      repeat (4) @(posedge clk);
      chk("drive1 deadband", 32'hffde, {16'h0, drv1});
      wr(tap_pkg::OFF_DBND, 32'h0);
      wr(tap_pkg::OFF_CFG, 32'h005);
      wr(tap_pkg::OFF_CTRL, 32'h1);
      repeat (4) @(posedge clk);
      chk("reached1 off", 32'h0, {31'h0, rch1});
   endtask : t_start
   task automatic t_jog();
      pins(1'b1, 16'h0300, 16'h0100);
      wr(tap_pkg::OFF_CTRL, 32'hb);
      repeat (4) @(posedge clk);
      chk("drive1 jog a", 32'h0400, {16'h0, drv1});
      rd("tgt1 jog", tap_pkg::OFF_TGT1, 32'h0300);
      wr(tap_pkg::OFF_CTRL, 32'h5);
      pins(1'b1, 16'h0310, 16'h0100);
      repeat (4) @(posedge clk);
      chk("drive1 jog b", 32'hfc00, {16'h0, drv1});
      wr(tap_pkg::OFF_CTRL, 32'h1);
      rd("tgt1 latch", tap_pkg::OFF_TGT1, 32'h0310);
   endtask : t_jog
   task automatic t_sync();
      wr(tap_pkg::OFF_CTRL, 32'h81);
      repeat (4) @(posedge clk);
      chk("drive2 follow", 32'h0630, {16'h0, drv2});
      wr(tap_pkg::OFF_CTRL, 32'h181);
      repeat (4) @(posedge clk);
      chk("drive1 average", 32'hfc28, {16'h0, drv1});
      chk("drive2 average", 32'h0258, {16'h0, drv2});
      pins(1'b1, 16'h0310, 16'h0308);
      wr(tap_pkg::OFF_CTRL, 32'hc1);
      repeat (4) @(posedge clk);
      chk("reached2", 32'h1, {31'h0, rch2});
      chk("drive2 near", 32'h0018, {16'h0, drv2});
   endtask : t_sync
   task automatic t_fail();
      wr(tap_pkg::OFF_FSV, 32'h0123);
      wr(tap_pkg::OFF_CFG, 32'h045);
      pins(1'b0, 16'h0310, 16'h0100);
      repeat (6) @(posedge clk);
      chk("ready off", 32'h0, {31'h0, rdy});
      chk("drive1 fs", 32'h0123, {16'h0, drv1});
      chk("drive2 fs", 32'h0, {16'h0, drv2});
   endtask : t_fail
   task automatic finish_test();
      miscompares += bm.timeouts;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : finish_test
   // Main sequence
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_enable();
      t_start();
      t_jog();
      t_sync();
      t_fail();
      finish_test();
   end
endmodule : tb_top
